/* File: core/pmm_compare.sv */
// greater-than comparator, signed or unsigned
`timescale 1ns/1ps
module pmm_compare
  import pmm_pkg::*;
#(
  parameter int W      = 16,
  parameter bit SIGNED = 1'b0
) (
  // operands
  input  wire logic [W-1:0] a_i,
  input  wire logic [W-1:0] b_i,
  // a above b
  output logic              gt_o
);

  assign gt_o = SIGNED ? ($signed(a_i) > $signed(b_i)) : (a_i > b_i);

endmodule

/* File: core/pmm_limit_regs.sv */
// limit and identification registers behind a two-wire serial slave
`timescale 1ns/1ps
module pmm_limit_regs
  import pmm_pkg::*;
#(
  parameter logic [6:0]  SLAVE_ADDR = 7'h40,
  parameter logic [15:0] MAKER_CODE = 16'h4142,  // arbitrary value
  parameter logic [11:0] PART_CODE  = 12'h5A5,   // arbitrary value
  parameter logic [3:0]  REVISION   = 4'h2       // arbitrary value
) (
  // clock and reset
  input  wire logic        CORE_CLK_I,
  input  wire logic        RSTN_I,
  // serial pins
  input  wire logic        SCL_I,
  input  wire logic        SDA_I,
  output logic             SDA_O,
  output logic             SDA_OE_O,
  // measurement results
  input  wire logic        SHUNT_RANGE_SELECT_I,
  input  wire pmm_meas_s   SHUNT_RESULT_I,
  input  wire pmm_meas_s   BUS_RESULT_I,
  input  wire pmm_meas_s   TEMP_RESULT_I,
  input  wire pmm_meas_s   POWER_RESULT_I,
  // limit events and scaled results
  output pmm_flags_s       FLAGS_O,
  output logic [29:0]      SHUNT_VOLTAGE_NV_O,
  output logic [27:0]      BUS_VOLTAGE_UV_O,
  output logic [19:0]      CHIP_TEMPERATURE_MC_O
);

  // ----------------------------------------------------------------
  // pin conditioning
  // ----------------------------------------------------------------
  logic scl_f;
  logic sda_f;
  logic scl_prev_q;
  logic sda_prev_q;

  pmm_pin_sync #(.RST_VAL(1'b1)) u_scl_sync (
    .clk_i   (CORE_CLK_I),
    .rstn_i  (RSTN_I),
    .pin_i   (SCL_I),
    .level_o (scl_f)
  );

  pmm_pin_sync #(.RST_VAL(1'b1)) u_sda_sync (
    .clk_i   (CORE_CLK_I),
    .rstn_i  (RSTN_I),
    .pin_i   (SDA_I),
    .level_o (sda_f)
  );

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  assign scl_rise  = scl_f & ~scl_prev_q;
  assign scl_fall  = ~scl_f & scl_prev_q;
  assign bus_start = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
  assign bus_stop  = scl_f & scl_prev_q & ~sda_prev_q & sda_f;

  // ----------------------------------------------------------------
  // threshold storage
  // ----------------------------------------------------------------
  logic [14:0] bus_high_threshold_q;
  logic [14:0] bus_high_threshold_d;
  logic [14:0] bus_low_threshold_q;
  logic [14:0] bus_low_threshold_d;
  logic [11:0] temperature_threshold_field_q;
  logic [11:0] temperature_threshold_field_d;
  logic [15:0] power_threshold_field_q;
  logic [15:0] power_threshold_field_d;

  logic        wr_en;
  logic [15:0] wr_data;
  logic [7:0]  ptr_q;
  logic [15:0] rd_data;

  always_comb begin
    rd_data = 16'h0000;
    if (ptr_q == PMM_REG_BUS_HIGH) begin
      rd_data = {1'b0, bus_high_threshold_q};
    end else if (ptr_q == PMM_REG_BUS_LOW) begin
      rd_data = {1'b0, bus_low_threshold_q};
    end else if (ptr_q == PMM_REG_TEMP_LIMIT) begin
      rd_data = {temperature_threshold_field_q, {PMM_TEMP_FIELD_LSB{1'b0}}};
    end else if (ptr_q == PMM_REG_POWER) begin
      rd_data = power_threshold_field_q;
    end else if (ptr_q == PMM_REG_MAKER) begin
      rd_data = MAKER_CODE;
    end else if (ptr_q == PMM_REG_PART) begin
      rd_data = {PART_CODE, REVISION};
    end
  end

  always_comb begin
    bus_high_threshold_d          = bus_high_threshold_q;
    bus_low_threshold_d           = bus_low_threshold_q;
    temperature_threshold_field_d = temperature_threshold_field_q;
    power_threshold_field_d       = power_threshold_field_q;
    // writes to identification or unmapped pointers are dropped
    if (wr_en) begin
      if (ptr_q == PMM_REG_BUS_HIGH) begin
        bus_high_threshold_d = wr_data[14:0];
      end else if (ptr_q == PMM_REG_BUS_LOW) begin
        bus_low_threshold_d = wr_data[14:0];
      end else if (ptr_q == PMM_REG_TEMP_LIMIT) begin
        temperature_threshold_field_d = wr_data[15:PMM_TEMP_FIELD_LSB];
      end else if (ptr_q == PMM_REG_POWER) begin
        power_threshold_field_d = wr_data;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      bus_high_threshold_q          <= PMM_BUS_HIGH_RST;
      bus_low_threshold_q           <= PMM_BUS_LOW_RST;
      temperature_threshold_field_q <= PMM_TEMP_RST;
      power_threshold_field_q       <= PMM_POWER_RST;
    end else begin
      bus_high_threshold_q          <= bus_high_threshold_d;
      bus_low_threshold_q           <= bus_low_threshold_d;
      temperature_threshold_field_q <= temperature_threshold_field_d;
      power_threshold_field_q       <= power_threshold_field_d;
    end
  end

  // ----------------------------------------------------------------
  // serial slave
  // ----------------------------------------------------------------
  pmm_state_e  st_q;
  pmm_state_e  st_d;
  logic [3:0]  bit_q;
  logic [3:0]  bit_d;
  logic [7:0]  shift_q;
  logic [7:0]  shift_d;
  logic        rw_q;
  logic        rw_d;
  logic [7:0]  ptr_d;
  logic [1:0]  byte_q;
  logic [1:0]  byte_d;
  logic [7:0]  msb_q;
  logic [7:0]  msb_d;
  logic [15:0] tx_q;
  logic [15:0] tx_d;
  logic        half_q;
  logic        half_d;
  logic        oe_q;
  logic        oe_d;
  logic        mack_q;
  logic        mack_d;

  assign wr_data = {msb_q, shift_q};

  always_comb begin
    st_d   = st_q;
    bit_d  = bit_q;
    shift_d = shift_q;
    rw_d   = rw_q;
    ptr_d  = ptr_q;
    byte_d = byte_q;
    msb_d  = msb_q;
    tx_d   = tx_q;
    half_d = half_q;
    oe_d   = oe_q;
    mack_d = mack_q;
    wr_en  = 1'b0;
    if (bus_stop) begin
      st_d = PMM_ST_IDLE;
      oe_d = 1'b0;
    end else if (bus_start) begin
      // repeated start keeps the pointer so a read can follow a pointer write
      st_d   = PMM_ST_ADDR;
      bit_d  = 4'd0;
      byte_d = 2'd0;
      oe_d   = 1'b0;
    end else begin
      case (st_q)
        PMM_ST_IDLE: begin
          oe_d = 1'b0;
        end
        PMM_ST_ADDR, PMM_ST_RX: begin
          if (scl_rise && bit_q != PMM_BITS_PER_BYTE) begin
            shift_d = {shift_q[6:0], sda_f};
            bit_d   = bit_q + 4'd1;
          end else if (scl_fall && bit_q == PMM_BITS_PER_BYTE) begin
            if (st_q == PMM_ST_ADDR) begin
              if (shift_q[7:1] == SLAVE_ADDR) begin
                oe_d = 1'b1;
                rw_d = shift_q[0];
                st_d = PMM_ST_ADDR_ACK;
              end else begin
                st_d = PMM_ST_IDLE;
              end
            end else begin
              oe_d = 1'b1;
              st_d = PMM_ST_RX_ACK;
              case (byte_q)
                2'd0: begin
                  ptr_d  = shift_q;
                  byte_d = 2'd1;
                end
                2'd1: begin
                  msb_d  = shift_q;
                  byte_d = 2'd2;
                end
                default: begin
                  wr_en  = 1'b1;
                  byte_d = 2'd1;
                end
              endcase
            end
          end
        end
        PMM_ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_q) begin
              tx_d   = rd_data;
              oe_d   = ~rd_data[15];
              bit_d  = 4'd1;
              half_d = 1'b0;
              st_d   = PMM_ST_TX;
            end else begin
              oe_d  = 1'b0;
              bit_d = 4'd0;
              st_d  = PMM_ST_RX;
            end
          end
        end
        PMM_ST_RX_ACK: begin
          if (scl_fall) begin
            oe_d  = 1'b0;
            bit_d = 4'd0;
            st_d  = PMM_ST_RX;
          end
        end
        PMM_ST_TX: begin
          if (scl_fall) begin
            if (bit_q == PMM_BITS_PER_BYTE) begin
              oe_d = 1'b0;
              st_d = PMM_ST_TX_ACK;
            end else begin
              tx_d  = {tx_q[14:0], 1'b0};
              oe_d  = ~tx_q[14];
              bit_d = bit_q + 4'd1;
            end
          end
        end
        PMM_ST_TX_ACK: begin
          if (scl_rise) begin
            mack_d = ~sda_f;
          end else if (scl_fall) begin
            if (!mack_q) begin
              st_d = PMM_ST_IDLE;
            end else if (half_q) begin
              // reads past the low byte repeat the same register
              tx_d   = rd_data;
              oe_d   = ~rd_data[15];
              half_d = 1'b0;
              bit_d  = 4'd1;
              st_d   = PMM_ST_TX;
            end else begin
              tx_d   = {tx_q[14:0], 1'b0};
              oe_d   = ~tx_q[14];
              half_d = 1'b1;
              bit_d  = 4'd1;
              st_d   = PMM_ST_TX;
            end
          end
        end
        default: begin
          st_d = PMM_ST_IDLE;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      st_q       <= PMM_ST_IDLE;
      bit_q      <= 4'd0;
      shift_q    <= 8'h00;
      rw_q       <= 1'b0;
      ptr_q      <= 8'h00;
      byte_q     <= 2'd0;
      msb_q      <= 8'h00;
      tx_q       <= 16'h0000;
      half_q     <= 1'b0;
      oe_q       <= 1'b0;
      mack_q     <= 1'b0;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      st_q       <= st_d;
      bit_q      <= bit_d;
      shift_q    <= shift_d;
      rw_q       <= rw_d;
      ptr_q      <= ptr_d;
      byte_q     <= byte_d;
      msb_q      <= msb_d;
      tx_q       <= tx_d;
      half_q     <= half_d;
      oe_q       <= oe_d;
      mack_q     <= mack_d;
      scl_prev_q <= scl_f;
      sda_prev_q <= sda_f;
    end
  end

  // open drain: the pad only ever pulls low
  assign SDA_O    = 1'b0;
  assign SDA_OE_O = oe_q;

  // ----------------------------------------------------------------
  // limit comparison and result scaling
  // ----------------------------------------------------------------
  logic bus_above;
  logic bus_below;
  logic temp_above;
  logic power_above;

  pmm_compare #(.W(16), .SIGNED(1'b0)) u_bus_high_cmp (
    .a_i  (BUS_RESULT_I.value[15:0]),
    .b_i  ({1'b0, bus_high_threshold_q}),
    .gt_o (bus_above)
  );

  pmm_compare #(.W(16), .SIGNED(1'b0)) u_bus_low_cmp (
    .a_i  ({1'b0, bus_low_threshold_q}),
    .b_i  (BUS_RESULT_I.value[15:0]),
    .gt_o (bus_below)
  );

  pmm_compare #(.W(PMM_TEMP_FIELD_W), .SIGNED(1'b1)) u_temp_cmp (
    .a_i  (TEMP_RESULT_I.value[11:0]),
    .b_i  (temperature_threshold_field_q),
    .gt_o (temp_above)
  );

  pmm_compare #(.W(PMM_POWER_RES_W), .SIGNED(1'b0)) u_power_cmp (
    .a_i  (POWER_RESULT_I.value),
    .b_i  ({power_threshold_field_q, {PMM_POWER_SHIFT{1'b0}}}),
    .gt_o (power_above)
  );

  pmm_flags_s  flags_q;
  pmm_flags_s  flags_d;
  logic [29:0] shunt_nv_q;
  logic [29:0] shunt_nv_d;
  logic [27:0] bus_uv_q;
  logic [27:0] bus_uv_d;
  logic [19:0] temp_mc_q;
  logic [19:0] temp_mc_d;
  logic [13:0] shunt_scale;

  assign shunt_scale = SHUNT_RANGE_SELECT_I ? PMM_SHUNT_NV_NARROW : PMM_SHUNT_NV_WIDE;

  always_comb begin
    shunt_nv_d = shunt_nv_q;
    bus_uv_d   = bus_uv_q;
    temp_mc_d  = temp_mc_q;
    // flags are one-cycle events, registered one cycle after the valid result
    flags_d.bus_high   = BUS_RESULT_I.valid & bus_above;
    flags_d.bus_low    = BUS_RESULT_I.valid & bus_below;
    flags_d.temp_high  = TEMP_RESULT_I.valid & temp_above;
    flags_d.power_high = POWER_RESULT_I.valid & power_above;
    // operands are widened to the product width so no partial product is lost
    if (SHUNT_RESULT_I.valid) begin
      shunt_nv_d = $signed({{14{SHUNT_RESULT_I.value[15]}}, SHUNT_RESULT_I.value[15:0]}) *
                   $signed({16'h0000, shunt_scale});
    end
    if (BUS_RESULT_I.valid) begin
      bus_uv_d = {12'h000, BUS_RESULT_I.value[15:0]} *
                 {16'h0000, PMM_BUS_UV_PER_LSB};
    end
    if (TEMP_RESULT_I.valid) begin
      temp_mc_d = $signed({{8{TEMP_RESULT_I.value[11]}}, TEMP_RESULT_I.value[11:0]}) *
                  $signed({12'h000, PMM_TEMP_MC_PER_LSB});
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      flags_q    <= '0;
      shunt_nv_q <= 30'h0;
      bus_uv_q   <= 28'h0;
      temp_mc_q  <= 20'h0;
    end else begin
      flags_q    <= flags_d;
      shunt_nv_q <= shunt_nv_d;
      bus_uv_q   <= bus_uv_d;
      temp_mc_q  <= temp_mc_d;
    end
  end

  assign FLAGS_O               = flags_q;
  assign SHUNT_VOLTAGE_NV_O    = shunt_nv_q;
  assign BUS_VOLTAGE_UV_O      = bus_uv_q;
  assign CHIP_TEMPERATURE_MC_O = temp_mc_q;

endmodule

/* File: core/pmm_pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pmm_pin_sync
  import pmm_pkg::*;
#(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // pin and filtered level
  input  wire logic pin_i,
  output logic      level_o
);

  logic [2:0] ff_q;
  logic [2:0] ff_d;
  logic       level_q;
  logic       level_d;

  always_comb begin
    ff_d    = {ff_q[1:0], pin_i};
    level_d = level_q;
    // a change counts only once stages two and three agree
    if (ff_q[1] == ff_q[2]) begin
      level_d = ff_q[2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ff_q    <= {3{RST_VAL}};
      level_q <= RST_VAL;
    end else begin
      ff_q    <= ff_d;
      level_q <= level_d;
    end
  end

  assign level_o = level_q;

endmodule

/* File: core/pmm_pkg.sv */
// shared constants and carrier types of the monitor limit and identification registers
package pmm_pkg;

  // ----------------------------------------------------------------
  // register pointers
  // ----------------------------------------------------------------
  localparam logic [7:0] PMM_REG_BUS_HIGH   = 8'h0E;
  localparam logic [7:0] PMM_REG_BUS_LOW    = 8'h0F;
  localparam logic [7:0] PMM_REG_TEMP_LIMIT = 8'h10;
  localparam logic [7:0] PMM_REG_POWER      = 8'h11;
  localparam logic [7:0] PMM_REG_MAKER      = 8'h3E;
  localparam logic [7:0] PMM_REG_PART       = 8'h3F;

  // ----------------------------------------------------------------
  // field layouts and reset values
  // ----------------------------------------------------------------
  localparam int          PMM_BUS_FIELD_W    = 15;
  localparam int          PMM_TEMP_FIELD_W   = 12;
  localparam int          PMM_TEMP_FIELD_LSB = 4;
  localparam int          PMM_POWER_FIELD_W  = 16;
  localparam int          PMM_POWER_RES_W    = 24;
  localparam int          PMM_POWER_SHIFT    = 8;
  localparam logic [14:0] PMM_BUS_HIGH_RST   = 15'h7FFF;
  localparam logic [14:0] PMM_BUS_LOW_RST    = 15'h0000;
  localparam logic [11:0] PMM_TEMP_RST       = 12'h7FF;
  localparam logic [15:0] PMM_POWER_RST      = 16'hFFFF;

  // ----------------------------------------------------------------
  // result scaling
  // ----------------------------------------------------------------
  localparam logic [13:0] PMM_SHUNT_NV_WIDE   = 14'd5000;
  localparam logic [13:0] PMM_SHUNT_NV_NARROW = 14'd1250;
  localparam logic [11:0] PMM_BUS_UV_PER_LSB  = 12'd3125;
  localparam logic [7:0]  PMM_TEMP_MC_PER_LSB = 8'd125;

  // ----------------------------------------------------------------
  // serial link
  // ----------------------------------------------------------------
  localparam logic [3:0] PMM_BITS_PER_BYTE = 4'd8;

  typedef enum logic [2:0] {
    PMM_ST_IDLE     = 3'b000,
    PMM_ST_ADDR     = 3'b001,
    PMM_ST_ADDR_ACK = 3'b011,
    PMM_ST_RX       = 3'b010,
    PMM_ST_RX_ACK   = 3'b110,
    PMM_ST_TX       = 3'b111,
    PMM_ST_TX_ACK   = 3'b101
  } pmm_state_e;

  typedef struct packed {
    logic        valid;
    logic [23:0] value;
  } pmm_meas_s;

  typedef struct packed {
    logic bus_high;
    logic bus_low;
    logic temp_high;
    logic power_high;
  } pmm_flags_s;

endpackage

/* File: sim/pmm_i2c_host.sv */
// behavioural two-wire host that reads and writes the limit registers
`timescale 1ns/1ps
module pmm_i2c_host (
  // clock
  input  wire logic clk_i,
  // wire level and host drive
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  // half bit of 8 clocks leaves room for the slave's sync and ack delay
  localparam int HALF = 8;

  initial begin
    scl_o    = 1'b1;
    sda_oe_o = 1'b0;
  end

  task automatic hw();
    repeat (HALF) @(posedge clk_i);
    #1;
  endtask
  // also serves as repeated start when entered with the clock low
  task automatic start();
    sda_oe_o = 1'b0;
    hw();
    scl_o = 1'b1;
    hw();
    sda_oe_o = 1'b1;
    hw();
    scl_o = 1'b0;
  endtask
  task automatic stop();
    sda_oe_o = 1'b1;
    hw();
    scl_o = 1'b1;
    hw();
    sda_oe_o = 1'b0;
    hw();
  endtask
  task automatic put_bit(input logic b, output logic s);
    sda_oe_o = ~b;
    hw();
    scl_o = 1'b1;
    hw();
    s     = sda_i;
    scl_o = 1'b0;
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(d[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask
  task automatic get_byte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, s);
      d[i] = s;
    end
    put_bit(~mack, s);
  endtask
  task automatic write_reg(input logic [6:0] a, input logic [7:0] p, input logic [15:0] v,
                           output logic ack);
    logic k;
    start();
    put_byte({a, 1'b0}, ack);
    put_byte(p, k);
    put_byte(v[15:8], k);
    put_byte(v[7:0], k);
    stop();
  endtask
  task automatic read_reg(input logic [6:0] a, input logic [7:0] p, output logic [15:0] v);
    logic k;
    start();
    put_byte({a, 1'b0}, k);
    put_byte(p, k);
    start();
    put_byte({a, 1'b1}, k);
    get_byte(1'b1, v[15:8]);
    get_byte(1'b0, v[7:0]);
    stop();
  endtask
endmodule

/* File: sim/pmm_limit_regs_assertions.sv */
// port checker of the monitor limit and identification registers
`timescale 1ns/1ps
module pmm_limit_regs_assertions
  import pmm_pkg::*;
(
  input wire logic        CORE_CLK_I,
  input wire logic        RSTN_I,
  input wire logic        SHUNT_RANGE_SELECT_I,
  input wire pmm_meas_s   SHUNT_RESULT_I,
  input wire pmm_meas_s   BUS_RESULT_I,
  input wire pmm_meas_s   TEMP_RESULT_I,
  input wire pmm_meas_s   POWER_RESULT_I,
  input wire pmm_flags_s  FLAGS_O,
  input wire logic [29:0] SHUNT_VOLTAGE_NV_O,
  input wire logic [27:0] BUS_VOLTAGE_UV_O,
  input wire logic [19:0] CHIP_TEMPERATURE_MC_O
);
  // ----------------------------------------------------------------
  // limit events and result scaling
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);

  // a result with bit 15 set is above any 15-bit threshold
  sequence s_bus_top;
    BUS_RESULT_I.valid && BUS_RESULT_I.value[15];
  endsequence
  sequence s_bus_zero;
    BUS_RESULT_I.valid && (BUS_RESULT_I.value[15:0] == 16'h0000);
  endsequence
  // the signed minimum can never lie above any threshold
  sequence s_temp_min;
    TEMP_RESULT_I.valid && (TEMP_RESULT_I.value[11:0] == 12'h800);
  endsequence
  sequence s_power_max;
    POWER_RESULT_I.valid && (POWER_RESULT_I.value == 24'hFFFFFF);
  endsequence

  AST_BUS_TOP: assert property (s_bus_top |=> FLAGS_O.bus_high && !FLAGS_O.bus_low)
    else $error("bus high event missing on top result");
  AST_BUS_ZERO: assert property (s_bus_zero |=> !FLAGS_O.bus_high)
    else $error("bus high event on zero result");
  AST_TEMP_MIN: assert property (s_temp_min |=> !FLAGS_O.temp_high)
    else $error("temperature event on signed minimum");
  AST_POWER_MAX: assert property (s_power_max |=> FLAGS_O.power_high)
    else $error("power event missing on full result");
  AST_NO_RESULT: assert property (!BUS_RESULT_I.valid && !TEMP_RESULT_I.valid
    && !POWER_RESULT_I.valid |=> FLAGS_O == 4'h0)
    else $error("limit event without a new result");
  AST_SHUNT_SCALE: assert property (SHUNT_RESULT_I.valid |=> SHUNT_VOLTAGE_NV_O ==
    30'($signed($past(SHUNT_RESULT_I.value[15:0])) *
    ($past(SHUNT_RANGE_SELECT_I) ? 30'sd1250 : 30'sd5000)))
    else $error("shunt voltage scaling wrong");
  AST_BUS_SCALE: assert property (BUS_RESULT_I.valid |=> BUS_VOLTAGE_UV_O ==
    28'($past(BUS_RESULT_I.value[15:0])) * 28'd3125)
    else $error("bus voltage scaling wrong");
  AST_TEMP_SCALE: assert property (TEMP_RESULT_I.valid |=> CHIP_TEMPERATURE_MC_O ==
    20'($signed($past(TEMP_RESULT_I.value[11:0])) * 20'sd125))
    else $error("temperature scaling wrong");
  AST_BUS_HOLD: assert property (!BUS_RESULT_I.valid |=> $stable(BUS_VOLTAGE_UV_O))
    else $error("bus voltage changed without a result");
endmodule

bind pmm_limit_regs pmm_limit_regs_assertions u_chk (
  .CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I), .SHUNT_RANGE_SELECT_I(SHUNT_RANGE_SELECT_I),
  .SHUNT_RESULT_I(SHUNT_RESULT_I), .BUS_RESULT_I(BUS_RESULT_I),
  .TEMP_RESULT_I(TEMP_RESULT_I), .POWER_RESULT_I(POWER_RESULT_I), .FLAGS_O(FLAGS_O),
  .SHUNT_VOLTAGE_NV_O(SHUNT_VOLTAGE_NV_O), .BUS_VOLTAGE_UV_O(BUS_VOLTAGE_UV_O),
  .CHIP_TEMPERATURE_MC_O(CHIP_TEMPERATURE_MC_O)
);

/* File: sim/pmm_limit_regs_tb.sv */
// self-checking bench of the monitor limit and identification registers
`timescale 1ns/1ps
module pmm_limit_regs_tb import pmm_pkg::*; ;
  // ----------------------------------------------------------------
  // bench signals and instances
  // ----------------------------------------------------------------
  localparam logic [6:0]  ADDR  = 7'h40;
  localparam logic [15:0] MAKER = 16'h4D4E;  // arbitrary value
  localparam logic [11:0] PART  = 12'h3C3;   // arbitrary value
  localparam logic [3:0]  REV   = 4'h7;      // arbitrary value
  logic        clk, rstn, scl, host_oe, range, sda_o, sda_oe;
  wire         sda;
  pmm_meas_s   sh, bu, te, pw;
  pmm_flags_s  flags;
  logic [29:0] sh_nv;
  logic [27:0] bu_uv;
  logic [19:0] te_mc;
  int          bad_count, comparisons;
  // pull-up: any enabled party pulls the data wire low
  assign sda = ~host_oe & (sda_oe ? sda_o : 1'b1);

  pmm_i2c_host u_host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));
  pmm_limit_regs #(.SLAVE_ADDR(ADDR), .MAKER_CODE(MAKER), .PART_CODE(PART), .REVISION(REV))
  dut (
    .CORE_CLK_I(clk), .RSTN_I(rstn), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE_O(sda_oe), .SHUNT_RANGE_SELECT_I(range), .SHUNT_RESULT_I(sh),
    .BUS_RESULT_I(bu), .TEMP_RESULT_I(te), .POWER_RESULT_I(pw), .FLAGS_O(flags),
    .SHUNT_VOLTAGE_NV_O(sh_nv), .BUS_VOLTAGE_UV_O(bu_uv), .CHIP_TEMPERATURE_MC_O(te_mc)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic fail(input string m);
    bad_count++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) fail($sformatf("register read %h expected %h", got, exp));
  endtask
  task automatic chk_flags(input pmm_flags_s got, input pmm_flags_s exp);
    comparisons++;
    if (got !== exp) fail($sformatf("events %b expected %b", got, exp));
  endtask
  task automatic chk_val(input logic [29:0] got, input logic [29:0] exp);
    comparisons++;
    if (got !== exp) fail($sformatf("scaled %h expected %h", got, exp));
  endtask
  task automatic wr(input logic [7:0] p, input logic [15:0] v);
    logic a;
    u_host.write_reg(ADDR, p, v, a);
  endtask
  task automatic rd_chk(input logic [7:0] p, input logic [15:0] exp);
    logic [15:0] v;
    u_host.read_reg(ADDR, p, v);
    chk_reg(v, exp);
  endtask
  // sel picks shunt, bus, temperature, power from bit 0 upward
  task automatic meas(input logic [3:0] sel, input logic [23:0] v, input pmm_flags_s ef);
    sh = {sel[0], v};
    bu = {sel[1], v};
    te = {sel[2], v};
    pw = {sel[3], v};
    @(posedge clk); #1;
    chk_flags(flags, ef);
    sh.valid = 1'b0;
    bu.valid = 1'b0;
    te.valid = 1'b0;
    pw.valid = 1'b0;
    @(posedge clk); #1;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd_chk(8'h0E, 16'h7FFF);
    rd_chk(8'h0F, 16'h0000);
    rd_chk(8'h10, 16'h7FF0);
    rd_chk(8'h11, 16'hFFFF);
    $display("test reset values done");
  endtask
  task automatic t_rw();
    wr(8'h0E, 16'hFFFF);
    rd_chk(8'h0E, 16'h7FFF);
    wr(8'h0F, 16'h8123);
    rd_chk(8'h0F, 16'h0123);
    wr(8'h10, 16'hFFFF);
    rd_chk(8'h10, 16'hFFF0);
    wr(8'h11, 16'h1234);
    rd_chk(8'h11, 16'h1234);
    $display("test write and read back done");
  endtask
  task automatic t_id();
    logic a;
    rd_chk(8'h3E, MAKER);
    rd_chk(8'h3F, {PART, REV});
    wr(8'h3E, 16'h0000);
    rd_chk(8'h3E, MAKER);
    rd_chk(8'h20, 16'h0000);
    u_host.write_reg(7'h41, 8'h0E, 16'h0001, a);
    comparisons++;
    if (a !== 1'b0) fail("foreign address acknowledged");
    rd_chk(8'h0E, 16'h7FFF);
    $display("test identification done");
  endtask
  task automatic t_bus();
    logic [15:0] v [6] = '{16'h0101, 16'h0100, 16'h007F, 16'h0080, 16'h8000, 16'h0000};
    logic [3:0]  e [6] = '{4'b1000, 4'b0000, 4'b0100, 4'b0000, 4'b1000, 4'b0100};
    wr(8'h0E, 16'h0100);
    wr(8'h0F, 16'h0080);
    for (int i = 0; i < 6; i++) meas(4'b0010, {8'h00, v[i]}, e[i]);
    $display("test bus limits done");
  endtask
  task automatic t_temp();
    wr(8'h10, 16'h0010);
    meas(4'b0100, 24'h000002, 4'b0010);
    meas(4'b0100, 24'h000001, 4'b0000);
    meas(4'b0100, 24'h000FFF, 4'b0000);
    wr(8'h10, 16'hFFF0);
    meas(4'b0100, 24'h000000, 4'b0010);
    meas(4'b0100, 24'h000FFE, 4'b0000);
    meas(4'b0100, 24'h0007FF, 4'b0010);
    meas(4'b0100, 24'h000800, 4'b0000);
    $display("test temperature limit done");
  endtask
  task automatic t_power();
    wr(8'h11, 16'h0002);
    meas(4'b1000, 24'h000201, 4'b0001);
    meas(4'b1000, 24'h000200, 4'b0000);
    meas(4'b1000, 24'hFFFFFF, 4'b0001);
    $display("test power limit done");
  endtask
  task automatic t_scale();
    range = 1'b0;
    meas(4'b0001, 24'h00FFFF, 4'b0000);
    chk_val(sh_nv, 30'(-5000));
    range = 1'b1;
    meas(4'b0001, 24'h000010, 4'b0000);
    chk_val(sh_nv, 30'(16 * 1250));
    meas(4'b0010, 24'h000080, 4'b0000);
    chk_val({2'b00, bu_uv}, 30'(128 * 3125));
    meas(4'b0100, 24'h000FF0, 4'b0000);
    chk_val({10'h000, te_mc}, {10'h000, 20'(-2000)});
    $display("test result scaling done");
  endtask
  // thresholds were rewritten by earlier tests, so this proves reset restores them
  task automatic t_mid_reset();
    rstn = 1'b0;
    repeat (5) @(posedge clk); #1;
    rstn = 1'b1;
    repeat (4) @(posedge clk); #1;
    t_reset();
    $display("test mid-run reset done");
  endtask

  task automatic report_and_stop();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    fail("watchdog expired");
    report_and_stop();
  end

  initial begin
    bad_count   = 0;
    comparisons = 0;
    rstn  = 1'b0;
    range = 1'b0;
    sh    = '0;
    bu    = '0;
    te    = '0;
    pw    = '0;
    repeat (5) @(posedge clk); #1;
    rstn = 1'b1;
    // a few edges to flush the pin synchronisers before the first start
    repeat (4) @(posedge clk); #1;
    t_reset();
    t_rw();
    t_id();
    t_bus();
    t_temp();
    t_power();
    t_scale();
    t_mid_reset();
    report_and_stop();
  end
endmodule
